// *** design/backup_gate_consts.svh ***
// Offsets, field positions, reset values and timing counts for the backup gating block.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef BACKUP_GATE_CONSTS_SVH
`define BACKUP_GATE_CONSTS_SVH

// Register byte offsets.
`define OFS_CTRL          4'h0
`define OFS_STATUS        4'h4
`define OFS_WDCOUNT       4'h8

// Control register fields and reset value.
`define CTRL_WD_EN_BIT    0
`define CTRL_RESET        1'h0

// AXI response codes.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// Clock period and internal timing tick (10.24 kHz nominal oscillator).
`define CLK_PERIOD_PS     5000
`define INT_TICK_PS       97656250
`define INT_TICK_CYCLES   ((`INT_TICK_PS) / (`CLK_PERIOD_PS))

// Watchdog timeout in ticks of the selected timing source.
`define WD_TIMEOUT_TICKS  1024

`endif

// *** design/backup_gate_pkg.sv ***
// Types shared by the backup gating block and its bench.
// Assumes nothing beyond the consts header for numeric values.
package backup_gate_pkg;

    // Observable status bits, as gathered into the status register.
    typedef struct packed {
        logic watchdogExpiredN;
        logic earlyFailWarnN;
        logic lowSupplyN;
        logic backupIndicator;
    } status_t;

    // Backup mode tracker states.
    typedef enum logic {
        MODE_NORMAL,
        MODE_BACKUP
    } mode_t;

endpackage : backup_gate_pkg

// *** design/backup_mode_output_gating.sv ***
// Output forcing and memory select gating of a supply supervisor, with an AXI4-Lite
// register slave. Assumes all comparator and pin inputs are synchronous to clk.
//
// Function
// - Backup mode forces all pin outputs to fixed levels.
// - Backup mode ignores early fail sense input.
// - Backup mode ignores watchdog kick input.
// - Backup mode ignores memory select request.
// - Valid supply passes memory select request through.
// - Low supply forces memory select high.
// - Warning low while sense below reference.
// - Warning follows raw compare, no hysteresis.
// - Enter backup at lower switchover margin.
// - Leave backup at upper switchover margin.
// - Low supply flag follows reset threshold.
`timescale 1ns/1ps
`include "backup_gate_consts.svh"

module backup_mode_output_gating
    import backup_gate_pkg::*;
#(
    parameter int unsigned INT_TICK_CYCLES = `INT_TICK_CYCLES,
    parameter int unsigned TIMEOUT_TICKS   = `WD_TIMEOUT_TICKS
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    // Comparator results.
    input  wire logic        supplyBelowReset,
    input  wire logic        supplyBelowBatt,
    input  wire logic        supplyAboveLowerMargin,
    input  wire logic        supplyAboveUpperMargin,
    input  wire logic        earlyFailSenseLow,
    // Processor side pins.
    input  wire logic        watchdogKickIn,
    input  wire logic        timingA,
    input  wire logic        timingSourceSel,
    input  wire logic        memSelectReqN,
    output logic             memSelectOutN,
    output logic             backupIndicator,
    output logic             earlyFailWarnN,
    output logic             resetOutN,
    output logic             resetOut,
    output logic             lowSupplyN,
    output logic             watchdogExpiredN,
    // AXI4-Lite slave.
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Mapped-address check, shared by the read and write paths.
    function automatic logic isMapped(input logic [3:0] addr);
        isMapped = (addr == `OFS_CTRL) || (addr == `OFS_STATUS) || (addr == `OFS_WDCOUNT);
    endfunction : isMapped

    mode_t       mode_r, mode_nxt;
    logic        inBackup;
    logic        supplyInvalid;
    status_t     status;

    // Backup mode tracker. The two margins give the switchover its hysteresis, so a
    // supply hovering near the battery level does not chatter between modes.
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_NORMAL: begin
                if (!supplyAboveLowerMargin) begin
                    mode_nxt = MODE_BACKUP;
                end
            end
            MODE_BACKUP: begin
                if (supplyAboveUpperMargin) begin
                    mode_nxt = MODE_NORMAL;
                end
            end
            default: mode_nxt = MODE_NORMAL;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= MODE_NORMAL;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    assign inBackup      = (mode_r == MODE_BACKUP);
    assign supplyInvalid = supplyBelowReset | supplyBelowBatt | inBackup;

    // Memory select gating has no register in the path, so the request reaches the
    // memory with only gate delay; the forcing term is the only other input.
    assign memSelectOutN = memSelectReqN | supplyInvalid;

    // Pin outputs. Backup forcing is tested first so nothing normal can override it.
    always_comb begin
        if (inBackup) begin
            backupIndicator = 1'b1;
            earlyFailWarnN  = 1'b0;
            resetOutN       = 1'b0;
            lowSupplyN      = 1'b0;
        end else begin
            backupIndicator = 1'b0;
            earlyFailWarnN  = ~earlyFailSenseLow;
            resetOutN       = ~supplyBelowReset;
            lowSupplyN      = ~supplyBelowReset;
        end
        resetOut = ~resetOutN;
    end

    // Watchdog. Inputs are sampled once to find edges of the kick and the external
    // timing clock; in backup or with the supply low the timer is frozen and cleared.
    logic        kickPrev_r, kickPrev_nxt;
    logic        timingPrev_r, timingPrev_nxt;
    logic [31:0] divCount_r, divCount_nxt;
    logic [31:0] wdCount_r, wdCount_nxt;
    logic        wdExpired_r, wdExpired_nxt;
    logic        ctrlWdEn_r, ctrlWdEn_nxt;
    logic        tick;
    logic        timerRun;

    assign timerRun = ctrlWdEn_r & ~supplyInvalid;

    always_comb begin
        kickPrev_nxt   = kickPrev_r;
        timingPrev_nxt = timingPrev_r;
        divCount_nxt   = divCount_r;
        wdCount_nxt    = wdCount_r;
        wdExpired_nxt  = wdExpired_r;
        tick           = 1'b0;
        if (!timerRun) begin
            divCount_nxt  = '0;
            wdCount_nxt   = '0;
            wdExpired_nxt = 1'b0;
        end else begin
            kickPrev_nxt   = watchdogKickIn;
            timingPrev_nxt = timingA;
            if (timingSourceSel) begin
                if (divCount_r >= INT_TICK_CYCLES - 1) begin
                    divCount_nxt = '0;
                    tick         = 1'b1;
                end else begin
                    divCount_nxt = divCount_r + 32'h1;
                end
            end else begin
                tick = timingA & ~timingPrev_r;
            end
            if (watchdogKickIn != kickPrev_r) begin
                wdCount_nxt   = '0;
                wdExpired_nxt = 1'b0;
            end else if (tick && !wdExpired_r) begin
                if (wdCount_r >= TIMEOUT_TICKS - 1) begin
                    wdExpired_nxt = 1'b1;
                end else begin
                    wdCount_nxt = wdCount_r + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kickPrev_r   <= 1'b0;
            timingPrev_r <= 1'b0;
            divCount_r   <= 32'h0;
            wdCount_r    <= 32'h0;
            wdExpired_r  <= 1'b0;
        end else begin
            kickPrev_r   <= kickPrev_nxt;
            timingPrev_r <= timingPrev_nxt;
            divCount_r   <= divCount_nxt;
            wdCount_r    <= wdCount_nxt;
            wdExpired_r  <= wdExpired_nxt;
        end
    end

    assign watchdogExpiredN = inBackup | ~wdExpired_r;

    assign status = '{watchdogExpiredN: watchdogExpiredN, earlyFailWarnN: earlyFailWarnN,
                      lowSupplyN: lowSupplyN, backupIndicator: backupIndicator};

    // AXI4-Lite slave. Address and data are held separately until both are present,
    // then the write lands and the response is raised on the following edge.
    logic        awHeld_r, awHeld_nxt;
    logic        wHeld_r, wHeld_nxt;
    logic [3:0]  awAddr_r, awAddr_nxt;
    logic [31:0] wData_r, wData_nxt;
    logic        wStrb0_r, wStrb0_nxt;
    logic        bValid_r, bValid_nxt;
    logic [1:0]  bResp_r, bResp_nxt;
    logic        rValid_r, rValid_nxt;
    logic [31:0] rData_r, rData_nxt;
    logic [1:0]  rResp_r, rResp_nxt;

    assign s_axi_awready = ~awHeld_r & ~bValid_r;
    assign s_axi_wready  = ~wHeld_r & ~bValid_r;
    assign s_axi_arready = ~rValid_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;

    always_comb begin
        awHeld_nxt   = awHeld_r;
        wHeld_nxt    = wHeld_r;
        awAddr_nxt   = awAddr_r;
        wData_nxt    = wData_r;
        wStrb0_nxt   = wStrb0_r;
        bValid_nxt   = bValid_r;
        bResp_nxt    = bResp_r;
        rValid_nxt   = rValid_r;
        rData_nxt    = rData_r;
        rResp_nxt    = rResp_r;
        ctrlWdEn_nxt = ctrlWdEn_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_nxt  = 1'b1;
            wData_nxt  = s_axi_wdata;
            wStrb0_nxt = s_axi_wstrb[0];
        end
        if (awHeld_r && wHeld_r && !bValid_r) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt  = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt  = isMapped(awAddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            if (awAddr_r == `OFS_CTRL && wStrb0_r) begin
                ctrlWdEn_nxt = wData_r[`CTRL_WD_EN_BIT];
            end
        end
        if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rResp_nxt  = isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `OFS_CTRL:    rData_nxt = {31'h0, ctrlWdEn_r};
                `OFS_STATUS:  rData_nxt = {27'h0, wdExpired_r, status};
                `OFS_WDCOUNT: rData_nxt = wdCount_r;
                default:      rData_nxt = 32'h0;
            endcase
        end else if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_r   <= 1'b0;
            wHeld_r    <= 1'b0;
            awAddr_r   <= 4'h0;
            wData_r    <= 32'h0;
            wStrb0_r   <= 1'b0;
            bValid_r   <= 1'b0;
            bResp_r    <= 2'h0;
            rValid_r   <= 1'b0;
            rData_r    <= 32'h0;
            rResp_r    <= 2'h0;
            ctrlWdEn_r <= `CTRL_RESET;
        end else begin
            awHeld_r   <= awHeld_nxt;
            wHeld_r    <= wHeld_nxt;
            awAddr_r   <= awAddr_nxt;
            wData_r    <= wData_nxt;
            wStrb0_r   <= wStrb0_nxt;
            bValid_r   <= bValid_nxt;
            bResp_r    <= bResp_nxt;
            rValid_r   <= rValid_nxt;
            rData_r    <= rData_nxt;
            rResp_r    <= rResp_nxt;
            ctrlWdEn_r <= ctrlWdEn_nxt;
        end
    end

endmodule : backup_mode_output_gating

// *** tb/cpu_model.sv ***
// Processor model that owns the memory select request.
// Assumes the bench puts the wanted request on cmdReqN.
`timescale 1ns/1ps
module cpu_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic earlyFailWarnN,
    input wire logic resetOutN,
    input wire logic cmdReqN,
    output logic     memSelectReqN
);
    logic holdOff_r;
    logic holdOff_nxt;
    // A low warning is an interrupt: a running processor stops memory traffic to shut down.
    always_comb holdOff_nxt = !earlyFailWarnN && resetOutN;
    // One cycle late, as no processor reacts within the same cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) holdOff_r <= 1'b0;
        else holdOff_r <= holdOff_nxt;
    end
    assign memSelectReqN = cmdReqN | holdOff_r;
endmodule : cpu_model

// *** tb/gating_monitor.sv ***
// Checker on the pin outputs of the backup gating block.
// Assumes it is bound into backup_mode_output_gating, whose ports carry these names.
`timescale 1ns/1ps
module gating_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supplyBelowReset,
    input wire logic supplyBelowBatt,
    input wire logic supplyAboveLowerMargin,
    input wire logic supplyAboveUpperMargin,
    input wire logic earlyFailSenseLow,
    input wire logic memSelectReqN,
    input wire logic memSelectOutN,
    input wire logic backupIndicator,
    input wire logic earlyFailWarnN,
    input wire logic resetOutN,
    input wire logic resetOut,
    input wire logic lowSupplyN,
    input wire logic watchdogExpiredN
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Mode triggers as seen in the old mode; the new mode must show one edge later.
    sequence goDown; !backupIndicator && !supplyAboveLowerMargin; endsequence
    sequence goUp; backupIndicator && supplyAboveUpperMargin; endsequence
    backup_force_a: assert property (
        backupIndicator |-> !earlyFailWarnN && !resetOutN && resetOut && !lowSupplyN
        && watchdogExpiredN && memSelectOutN) else $error("backup levels wrong");
    enter_backup_a: assert property (goDown |=> backupIndicator) else $error("no entry");
    leave_backup_a: assert property (goUp |=> !backupIndicator) else $error("no exit");
    hold_backup_a: assert property (
        backupIndicator && !supplyAboveUpperMargin |=> backupIndicator) else $error("left early");
    mem_pass_a: assert property (
        !(supplyBelowReset || supplyBelowBatt || backupIndicator)
        |-> memSelectOutN == memSelectReqN) else $error("select not passed");
    mem_force_a: assert property (
        supplyBelowReset || supplyBelowBatt |-> memSelectOutN) else $error("select not forced");
    warn_follow_a: assert property (
        !backupIndicator |-> earlyFailWarnN == !earlyFailSenseLow) else $error("warning wrong");
    low_flag_a: assert property (
        !backupIndicator |-> lowSupplyN == !supplyBelowReset
        && resetOutN == !supplyBelowReset && resetOut != resetOutN)
        else $error("low flag wrong");
endmodule : gating_monitor

bind backup_mode_output_gating gating_monitor mon (.*);

// *** tb/tb_backup_mode_output_gating.sv ***
// Bench for the backup gating block: pin rows, registers, watchdog, backup mode.
// Assumes tick and timeout counts shortened to 4 so the run stays short.
`timescale 1ns/1ps
`include "backup_gate_consts.svh"
module tb_backup_mode_output_gating;
    logic        clk, nrst, supplyBelowReset, supplyBelowBatt, supplyAboveLowerMargin;
    logic        supplyAboveUpperMargin, earlyFailSenseLow, watchdogKickIn, timingA, cmdReqN;
    logic        timingSourceSel, memSelectReqN, memSelectOutN, backupIndicator, resetOut;
    logic        earlyFailWarnN, resetOutN, lowSupplyN, watchdogExpiredN, s_axi_awvalid;
    logic        s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tk, tr;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    // Rows: {belowReset, belowBatt, senseLow, request, select out, warning, low flag}.
    logic [6:0]  rows [8] = '{7'h03, 7'h0f, 7'h46, 7'h27, 7'h15, 7'h74, 7'h03, 7'h4e};

    backup_mode_output_gating #(.INT_TICK_CYCLES(4), .TIMEOUT_TICKS(4)) uut (.*);
    cpu_model cpu (.*);

    // Free running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // A hang is cut short; the whole run needs under two hundred cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Lets the partner's one-cycle reaction land before outputs are looked at.
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // Ready and valid are read mid-cycle, so they equal what the next rising edge sees.
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge clk);
            {tk, tr, rsp} = {s_axi_awready, s_axi_wready, s_axi_bresp};
            rd[0] = s_axi_bvalid;
            @(posedge clk);
            if (tk) s_axi_awvalid <= 1'b0;
            if (tr) s_axi_wvalid <= 1'b0;
        end while (!rd[0]);
        s_axi_bready <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [3:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge clk);
            {tk, tr, rd, rsp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk);
            if (tk) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
    endtask : axiRead

    initial begin
        nrst = 1'b0;
        {supplyBelowReset, supplyBelowBatt, earlyFailSenseLow, watchdogKickIn, timingA} = '0;
        {supplyAboveLowerMargin, supplyAboveUpperMargin, timingSourceSel, cmdReqN} = '1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hf};
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            {supplyBelowReset, supplyBelowBatt, earlyFailSenseLow, cmdReqN} <= rows[i][6:3];
            settle();
            check(32'({memSelectOutN, earlyFailWarnN, lowSupplyN}), 32'(rows[i][2:0]));
        end
        $display("row test done");
        // Registers, with an unmapped place; the watchdog then runs on a steady kick.
        @(posedge clk);
        supplyBelowReset <= 1'b0;
        axiWrite(`OFS_CTRL, 32'h1);
        check(32'(rsp), 32'(`RESP_OKAY));
        axiRead(`OFS_CTRL);
        check(rd, 32'h1);
        check(32'(rsp), 32'(`RESP_OKAY));
        axiRead(4'hc);
        // Response and data are compared apart, so neither is cut off by a narrowing cast.
        check(rd, 32'h0);
        check(32'(rsp), 32'(`RESP_SLVERR));
        repeat (40) @(posedge clk);
        @(negedge clk);
        check(32'(watchdogExpiredN), 32'h0);
        $display("register test done");
        // Backup mode is entered with the watchdog expired; every ignored input but the memory select request, held low, is shaken.
        @(posedge clk);
        {supplyAboveLowerMargin, supplyAboveUpperMargin, cmdReqN} <= 3'h0;
        settle();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {earlyFailSenseLow, watchdogKickIn, timingA, timingSourceSel} <= 4'(i * 5);
            @(negedge clk);
            check(32'({memSelectOutN, backupIndicator, earlyFailWarnN, resetOutN, resetOut,
                lowSupplyN, watchdogExpiredN}), 32'h65);
        end
        axiRead(`OFS_STATUS);
        check(rd, 32'h9);
        @(posedge clk);
        {supplyAboveLowerMargin, supplyAboveUpperMargin} <= 2'h3;
        settle();
        check(32'({backupIndicator, memSelectOutN, earlyFailWarnN}), 32'h1);
        $display("backup test done");
        // Reset in mid-run with backup pending: the mode must stay normal while reset holds.
        @(posedge clk);
        {supplyAboveLowerMargin, supplyAboveUpperMargin, nrst} <= 3'h0;
        repeat (3) @(negedge clk);
        check(32'({backupIndicator, watchdogExpiredN, s_axi_awready, s_axi_arready}), 32'h7);
        @(posedge clk);
        {supplyAboveLowerMargin, supplyAboveUpperMargin, nrst} <= 3'h7;
        axiRead(`OFS_CTRL);
        check(rd, 32'(`CTRL_RESET));
        check(32'(watchdogExpiredN), 32'h1);
        $display("reset test done");
        end_of_test();
    end
endmodule : tb_backup_mode_output_gating
